// File: video_test_defines.svh
`ifndef VIDEO_TEST_DEFINES_SVH
`define VIDEO_TEST_DEFINES_SVH

// Register indices on the 8-bit microinterface
`define IDX_REVISION 8'h01
`define IDX_SENSE 8'h3A
`define IDX_CRC_LOW 8'h3C
`define IDX_CRC_HIGH 8'h3D
`define IDX_LINE_SELECT 8'h3E
`define IDX_IDENTITY 8'h3F
`define IDX_SOFT_RESET 8'hFF

// Field positions and reset values
`define SENSE_OFF_BIT 7
`define SENSE_OFF_RST 1'h0
`define SENSE_RESULT_RST 3'h0
`define LINE_SELECT_RST 5'h00
`define LINE_SELECT_MAX 5'h17
`define READ_UNMAPPED 8'h00

// CRC engine defaults
`define CRC_SEED 16'h0000
`define CRC_POLY 16'h1021

// Horizontal sync pulses in blanking that mark vertical retrace
`define RETRACE_HS_COUNT 2'h2

`endif

// File: video_test_pkg.sv
package video_test_pkg;

   // Host sequencer states, one-hot
   typedef enum logic [2:0] {
      HOST_IDLE = 3'b001,
      HOST_ISSUE = 3'b010,
      HOST_WAIT = 3'b100
   } host_state_t;

   typedef logic [7:0] reg_byte_t;

endpackage

// File: micro_if.sv
`timescale 1ns/1ps
interface micro_if;
   logic [7:0] index; // Register index
   logic [7:0] wdata; // Write data
   logic [7:0] rdata; // Read data
   logic wr; // One-cycle write strobe
   logic rd; // One-cycle read strobe
   logic rvalid; // Read data valid pulse

   modport dev (
      input index, wdata, wr, rd,
      output rdata, rvalid
   );

   modport host (
      output index, wdata, wr, rd,
      input rdata, rvalid
   );
endinterface

// File: crc16_engine.sv
`timescale 1ns/1ps
`include "video_test_defines.svh"
module crc16_engine #(
   parameter int WIDTH = 16,
   parameter logic [15:0] POLY = `CRC_POLY,
   parameter logic [15:0] SEED = `CRC_SEED
) (
   input wire logic clock, // Dot clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic clear, // Restart from the seed
   input wire logic shift, // Fold one bit in this cycle
   input wire logic din, // Selected data bit
   output logic [WIDTH-1:0] crc // Running remainder
);

   generate
      if (WIDTH != 16) begin : g_bad_width
         $error("crc16_engine supports only a 16-bit remainder");
      end
   endgenerate

   logic feedback;

   // Serial feedback of the top bit against the incoming bit
   assign feedback = crc[WIDTH-1] ^ din;

   // One step per dot clock while shifting; clear wins over shift
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         crc <= SEED;
      end else if (clear) begin
         crc <= SEED;
      end else if (shift) begin
         crc <= {crc[WIDTH-2:0], 1'b0} ^ (feedback ? POLY : '0);
      end
   end

endmodule

// File: video_test_device.sv
// Overview of operation
// - CRC-16 over one selected DAC input line
// - Remainder updated on two hsyncs in blanking
// - Sync source drives hsync active low
// - CRC advances only outside blanking
// - Result valid after one full screen
// - Remainder read as low and high bytes
// - Sense low when any comparator trips
// - Sense register bits zeros, red, green, blue
// - Bit seven disables comparison, reset zero
// - Disabling write clears bits six to zero
// - Sense captured on sampled blank falling edge
// - Pixel data held steady around blank edge
// - Read-only hardwired identity byte
// - Revision byte, major high, minor low
// - Any soft reset write restores defaults
// - Reset pin low asynchronously restores defaults
// - Software treats changed CRC as error
`timescale 1ns/1ps
`include "video_test_defines.svh"
module video_test_device #(
   parameter int DATA_LINES = 24,
   parameter logic [15:0] CRC_POLY = `CRC_POLY,
   parameter logic [7:0] IDENTITY_CODE = 8'h5A, // Arbitrary value
   parameter logic [7:0] REVISION_CODE = 8'h11 // Arbitrary value
) (
   input wire logic clock, // Dot clock
   input wire logic rst_b, // Reset, active low, asynchronous
   micro_if.dev bus, // Microinterface register port
   input wire logic [DATA_LINES-1:0] dac_data, // Data entering the DACs
   input wire logic hsync_n, // Horizontal sync, active low
   input wire logic system_blank_in_n, // System blank, active low
   input wire logic legacy_blank_in_n, // Legacy port blank, active low
   input wire logic blank_source_select, // 1 picks the system blank
   input wire logic red_current_out_high, // Red comparator above level
   input wire logic green_current_out_high, // Green comparator above level
   input wire logic blue_current_out_high, // Blue comparator above level
   output logic sense_n, // Monitor sense, active low
   output logic crc_valid // Remainder covers a full screen
);

   generate
      if (DATA_LINES != 24) begin : g_bad_lines
         $error("video_test_device serves exactly 24 data lines");
      end
   endgenerate

   // Index decode used by both the write and read paths
   function automatic logic hit(input logic [7:0] index,
                                input logic [7:0] target);
      hit = (index == target);
   endfunction

   logic soft_reset;
   logic line_write;
   logic sense_write;
   logic blank_n;
   logic blank_n_q;
   logic blank_fall;
   logic hsync_n_q;
   logic hsync_fall;
   logic retrace;
   logic [1:0] hs_count_q;
   logic started_q;
   logic [4:0] line_select_q;
   logic compare_off_q;
   logic [2:0] sense_result_q;
   logic [15:0] crc_now;
   logic [15:0] remainder_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic crc_clear;
   logic crc_bit;

   // Write strobes; any data to the soft reset index counts
   assign soft_reset = bus.wr && hit(bus.index, `IDX_SOFT_RESET);
   assign sense_write = bus.wr && hit(bus.index, `IDX_SENSE);
   assign line_write = bus.wr && hit(bus.index, `IDX_LINE_SELECT)
      && (bus.wdata[4:0] <= `LINE_SELECT_MAX)
      && (bus.wdata[7:5] == 3'h0);

   // Internal blank chosen from the two blank sources
   assign blank_n = blank_source_select ? system_blank_in_n
                                        : legacy_blank_in_n;

   // Edge history of blank and horizontal sync
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         blank_n_q <= 1'b1;
         hsync_n_q <= 1'b1;
      end else begin
         blank_n_q <= blank_n;
         hsync_n_q <= hsync_n;
      end
   end

   assign blank_fall = blank_n_q && !blank_n;
   assign hsync_fall = hsync_n_q && !hsync_n;

   // Count sync pulses inside one blanking period; active video restarts
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         hs_count_q <= 2'h0;
      end else if (soft_reset || blank_n) begin
         hs_count_q <= 2'h0;
      end else if (hsync_fall && hs_count_q != `RETRACE_HS_COUNT) begin
         hs_count_q <= hs_count_q + 2'h1;
      end
   end

   // Second sync pulse of one blanking period: vertical retrace
   assign retrace = !blank_n && hsync_fall
      && (hs_count_q == `RETRACE_HS_COUNT - 2'h1);

   // Line select; out-of-range writes are dropped so the mux stays legal
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         line_select_q <= `LINE_SELECT_RST;
      end else if (soft_reset) begin
         line_select_q <= `LINE_SELECT_RST;
      end else if (line_write) begin
         line_select_q <= bus.wdata[4:0];
      end
   end

   // Serial source bit taken from the chosen converter line
   assign crc_bit = dac_data[line_select_q];

   // A new line or a retrace starts a fresh screen
   assign crc_clear = soft_reset || retrace || line_write;

   crc16_engine #(
      .WIDTH(16),
      .POLY(CRC_POLY),
      .SEED(`CRC_SEED)
   ) u_crc (
      .clock(clock),
      .rst_b(rst_b),
      .clear(crc_clear),
      .shift(blank_n),
      .din(crc_bit),
      .crc(crc_now)
   );

   // Screen tracking: the first retrace only marks the start
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         started_q <= 1'b0;
      end else if (soft_reset || line_write) begin
         started_q <= 1'b0;
      end else if (retrace) begin
         started_q <= 1'b1;
      end
   end

   // Remainder and valid flag; partial screens never publish
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         remainder_q <= `CRC_SEED;
         crc_valid <= 1'b0;
      end else if (soft_reset) begin
         remainder_q <= `CRC_SEED;
         crc_valid <= 1'b0;
      end else if (line_write) begin
         crc_valid <= 1'b0;
      end else if (retrace && started_q) begin
         remainder_q <= crc_now;
         crc_valid <= 1'b1;
      end
   end

   // Disable bit; only bit seven of a sense write is stored
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         compare_off_q <= `SENSE_OFF_RST;
      end else if (soft_reset) begin
         compare_off_q <= `SENSE_OFF_RST;
      end else if (sense_write) begin
         compare_off_q <= bus.wdata[`SENSE_OFF_BIT];
      end
   end

   // Comparators sampled on falling blank; data must be still then
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sense_result_q <= `SENSE_RESULT_RST;
         sense_n <= 1'b1;
      end else if (soft_reset) begin
         sense_result_q <= `SENSE_RESULT_RST;
         sense_n <= 1'b1;
      end else if (blank_fall) begin
         if (compare_off_q) begin
            sense_result_q <= `SENSE_RESULT_RST;
            sense_n <= 1'b1;
         end else begin
            sense_result_q <= {red_current_out_high,
                               green_current_out_high,
                               blue_current_out_high};
            sense_n <= !(red_current_out_high || green_current_out_high
                         || blue_current_out_high);
         end
      end
   end

   // Read data registered one cycle after the strobe
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= `READ_UNMAPPED;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= bus.rd;
         if (bus.rd) begin
            if (hit(bus.index, `IDX_REVISION)) begin
               rdata_q <= REVISION_CODE;
            end else if (hit(bus.index, `IDX_SENSE)) begin
               // Results masked while disabled, even before blank falls
               rdata_q <= {compare_off_q, 4'h0,
                  compare_off_q ? `SENSE_RESULT_RST : sense_result_q};
            end else if (hit(bus.index, `IDX_CRC_LOW)) begin
               rdata_q <= remainder_q[7:0];
            end else if (hit(bus.index, `IDX_CRC_HIGH)) begin
               rdata_q <= remainder_q[15:8];
            end else if (hit(bus.index, `IDX_LINE_SELECT)) begin
               rdata_q <= {3'h0, line_select_q};
            end else if (hit(bus.index, `IDX_IDENTITY)) begin
               rdata_q <= IDENTITY_CODE;
            end else begin
               rdata_q <= `READ_UNMAPPED;
            end
         end
      end
   end

   assign bus.rdata = rdata_q;
   assign bus.rvalid = rvalid_q;

endmodule

// File: test_host.sv
`timescale 1ns/1ps
`include "video_test_defines.svh"
module test_host (
   input wire logic clock, // System clock
   input wire logic rst_b, // Synchronous reset, active low
   micro_if.host bus, // Microinterface toward the device
   input wire logic cmd_valid, // Request present
   input wire logic cmd_write, // 1 write, 0 read
   input wire logic [7:0] cmd_index, // Register index
   input wire logic [7:0] cmd_wdata, // Write data
   output logic cmd_ready, // Request taken this cycle
   output logic rsp_valid, // Read answer pulse
   output logic [7:0] rsp_data // Read answer data
);

   video_test_pkg::host_state_t state_q;
   logic wr_q;
   logic rd_q;
   logic [7:0] index_q;
   logic [7:0] wdata_q;
   logic bad_line;
   logic disabling;

   // Line select beyond the last converter line is never sent
   assign bad_line = cmd_write && (cmd_index == `IDX_LINE_SELECT)
      && (cmd_wdata > {3'h0, `LINE_SELECT_MAX});
   assign disabling = cmd_write && (cmd_index == `IDX_SENSE)
      && cmd_wdata[`SENSE_OFF_BIT];

   assign cmd_ready = (state_q == video_test_pkg::HOST_IDLE);

   // Sequencer: one strobe cycle, then wait for read data if reading
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_q <= video_test_pkg::HOST_IDLE;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         index_q <= 8'h00;
         wdata_q <= 8'h00;
      end else begin
         unique case (state_q)
            video_test_pkg::HOST_IDLE: begin
               if (cmd_valid) begin
                  state_q <= video_test_pkg::HOST_ISSUE;
                  wr_q <= cmd_write && !bad_line;
                  rd_q <= !cmd_write;
                  index_q <= cmd_index;
                  // Disabling write carries zeros below bit seven
                  wdata_q <= disabling ? 8'h80 : cmd_wdata;
               end
            end
            video_test_pkg::HOST_ISSUE: begin
               wr_q <= 1'b0;
               rd_q <= 1'b0;
               state_q <= rd_q ? video_test_pkg::HOST_WAIT
                               : video_test_pkg::HOST_IDLE;
            end
            video_test_pkg::HOST_WAIT: begin
               if (bus.rvalid) begin
                  state_q <= video_test_pkg::HOST_IDLE;
               end
            end
            default: begin
               state_q <= video_test_pkg::HOST_IDLE;
            end
         endcase
      end
   end

   // Answer captured from the device read data
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
      end else begin
         rsp_valid <= (state_q == video_test_pkg::HOST_WAIT) && bus.rvalid;
         if ((state_q == video_test_pkg::HOST_WAIT) && bus.rvalid) begin
            rsp_data <= bus.rdata;
         end
      end
   end

   assign bus.wr = wr_q;
   assign bus.rd = rd_q;
   assign bus.index = index_q;
   assign bus.wdata = wdata_q;

endmodule

// File: micro_bus_props.sv
`timescale 1ns/1ps
module micro_bus_props #(
   parameter logic [7:0] IDENTITY_CODE = 8'h5A, // Arbitrary value
   parameter logic [7:0] REVISION_CODE = 8'h11 // Arbitrary value
) (
   input wire logic clock, // Dot clock
   input wire logic rst_b, // Reset, active low
   input wire logic [7:0] index, // Register index
   input wire logic [7:0] wdata, // Write data
   input wire logic [7:0] rdata, // Read data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   input wire logic rvalid // Read answer pulse
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   // Answer timing, one cycle after the strobe and never without one
   read_answer_a: assert property (rd |=> rvalid)
      else $error("read strobe got no answer");
   answer_cause_a: assert property (rvalid |-> $past(rd))
      else $error("answer without read strobe");
   // Writes must not disturb the last answer seen by the host
   rdata_hold_a: assert property (!rd |=> $stable(rdata))
      else $error("read data moved without a read");
   // Hardwired bytes
   ident_read_a: assert property (
      rd && index == 8'h3F |=> rdata == IDENTITY_CODE)
      else $error("identity byte wrong");
   revision_read_a: assert property (
      rd && index == 8'h01 |=> rdata == REVISION_CODE)
      else $error("revision byte wrong");
   // Reserved bits zero, and no results while disabled
   sense_layout_a: assert property (
      rd && index == 8'h3A |=> rdata[6:3] == 4'h0 &&
      !(rdata[7] && rdata[2:0] != 3'h0))
      else $error("sense byte layout wrong");
   line_range_a: assert property (
      rd && index == 8'h3E |=> rdata <= 8'h17)
      else $error("line select out of range");
   // Host side must never put an illegal select or a disable write with stray low bits on the wire
   line_write_legal_a: assert property (
      wr && index == 8'h3E |-> wdata <= 8'h17)
      else $error("illegal line select written");
   disable_clean_a: assert property (
      wr && index == 8'h3A && wdata[7] |-> wdata[6:0] == 7'h00)
      else $error("disable write with stray bits");
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
   localparam logic [7:0] ID_V = 8'h5A; // Arbitrary value
   localparam logic [7:0] REV_V = 8'h11; // Arbitrary value
   localparam logic [15:0] POLY_V = 16'h1021;
   logic clock = 0, rst_b = 0, cv = 0, cw = 0, cr, rv, hs_n = 1;
   logic sb_n = 1, lb_n = 1, bsel = 1, r_hi = 0, g_hi = 0, b_hi = 0;
   logic sense_n, crc_valid;
   logic [7:0] ci = 8'h00, cd = 8'h00, rd_v, got;
   logic [23:0] dac = 24'h00_0000;
   logic [23:0] pat = 24'h00_0000;
   logic [15:0] crc_m;
   logic [4:0] sel;
   int error_cnt = 0, checks_done = 0;
   micro_if mif();
   test_host u_test_host (.clock(clock), .rst_b(rst_b), .bus(mif.host),
      .cmd_valid(cv), .cmd_write(cw), .cmd_index(ci), .cmd_wdata(cd),
      .cmd_ready(cr), .rsp_valid(rv), .rsp_data(rd_v));
   video_test_device #(.DATA_LINES(24), .CRC_POLY(POLY_V),
      .IDENTITY_CODE(ID_V), .REVISION_CODE(REV_V)) u_video_test_device (
      .clock(clock), .rst_b(rst_b), .bus(mif.dev), .dac_data(dac),
      .hsync_n(hs_n), .system_blank_in_n(sb_n), .legacy_blank_in_n(lb_n),
      .blank_source_select(bsel), .red_current_out_high(r_hi),
      .green_current_out_high(g_hi), .blue_current_out_high(b_hi),
      .sense_n(sense_n), .crc_valid(crc_valid));
   micro_bus_props #(.IDENTITY_CODE(ID_V), .REVISION_CODE(REV_V))
      u_micro_bus_props (.clock(clock), .rst_b(rst_b), .index(mif.index),
      .wdata(mif.wdata), .rdata(mif.rdata), .wr(mif.wr), .rd(mif.rd),
      .rvalid(mif.rvalid));

   initial begin
      forever #5 clock = ~clock;
   end

   // Galois step, same feedback as the engine
   function automatic logic [15:0] step(input logic [15:0] c,
                                        input logic b);
      step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? POLY_V : 16'h0000);
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // One host request; waits bounded for ready and for the answer
   task automatic op(input logic w, input logic [7:0] i, d);
      int n;
      n = 0;
      while (cr !== 1'b1 && n < 20) begin @(negedge clock); n++; end
      cv = 1; cw = w; ci = i; cd = d;
      @(negedge clock);
      cv = 0;
      n = 0;
      while (!w && rv !== 1'b1 && n < 10) begin @(negedge clock); n++; end
      got = rd_v;
   endtask

   task automatic rchk(input logic [7:0] i, e);
      op(0, i, 8'h00);
      `CHK(got, e)
   endtask

   // Pixel data left still around the blank edge
   task automatic blank_fall(input logic sys);
      @(negedge clock);
      if (sys) sb_n = 0; else lb_n = 0;
      repeat (3) @(negedge clock);
      sb_n = 1; lb_n = 1;
      @(negedge clock);
   endtask

   // Blanking with n sync pulses; pixel data keeps changing meanwhile
   // Stay leaves blank low so later reads add no shifts
   task automatic blanking(input int n, input bit stay = 1'b0);
      sb_n = 0;
      repeat (n) begin
         repeat (3) begin @(negedge clock); dac = 24'($urandom); end
         hs_n = 0;
         repeat (3) @(negedge clock);
         hs_n = 1;
      end
      repeat (3) @(negedge clock);
      if (!stay) sb_n = 1;
   endtask

   // Active video; hold keeps one still pattern on the data lines
   task automatic active(input int n, input bit hold = 1'b0);
      repeat (n) begin
         dac = hold ? pat : 24'($urandom);
         @(posedge clock);
         crc_m = step(crc_m, dac[sel]);
         @(negedge clock);
      end
   endtask

   initial begin
      void'($urandom(87190));
      repeat (20) @(negedge clock);
      rst_b = 1;
      rchk(8'h3F, ID_V);
      rchk(8'h01, REV_V);
      rchk(8'h3A, 8'h00);
      rchk(8'h3E, 8'h00);
      rchk(8'h02, 8'h00);
      op(1, 8'h3F, 8'hC3); op(1, 8'h01, 8'h3C);
      rchk(8'h3F, ID_V);
      rchk(8'h01, REV_V);
      sel = 5'($urandom_range(23));
      op(1, 8'h3E, {3'h0, sel}); op(1, 8'h3E, 8'h18);
      rchk(8'h3E, {3'h0, sel});
      $display("test registers done");
      for (int k = 0; k < 8; k++) begin
         {r_hi, g_hi, b_hi} = 3'(k); bsel = k[0];
         blank_fall(k[0]);
         `CHK(sense_n, (k == 0))
         {r_hi, g_hi, b_hi} = ~3'(k);
         blank_fall(!k[0]);
         rchk(8'h3A, 8'(k));
      end
      // Stray low bits stripped by the host; all comparators trip
      op(1, 8'h3A, 8'h85);
      {r_hi, g_hi, b_hi} = 3'h7;
      blank_fall(bsel);
      rchk(8'h3A, 8'h80);
      `CHK(sense_n, 1'b1)
      $display("test sense done");
      bsel = 1;
      for (int k = 0; k < 3; k++) begin
         sel = (k == 0) ? 5'h00 : (k == 1) ? 5'h17 : 5'($urandom_range(23));
         op(1, 8'h3E, {3'h0, sel});
         blanking(2);
         crc_m = 16'h0000;
         repeat (3) begin active(40); blanking(1); end
         active(40);
         `CHK(crc_valid, 1'b0)
         blanking(2);
         `CHK(crc_valid, 1'b1)
         rchk(8'h3C, crc_m[7:0]);
         rchk(8'h3D, crc_m[15:8]);
      end
      // A still picture must give the same remainder every screen
      pat = 24'($urandom);
      blanking(2);
      for (int s = 0; s < 2; s++) begin
         crc_m = 16'h0000;
         active(40, 1'b1);
         blanking(2, 1'b1);
         rchk(8'h3C, crc_m[7:0]);
         rchk(8'h3D, crc_m[15:8]);
         sb_n = 1;
      end
      $display("test crc done");
      op(1, 8'hFF, 8'($urandom));
      rchk(8'h3E, 8'h00);
      rchk(8'h3C, 8'h00);
      rchk(8'h3A, 8'h00);
      `CHK(crc_valid, 1'b0)
      $display("test soft reset done");
      op(1, 8'h3E, 8'h07); r_hi = 1;
      blank_fall(1);
      rst_b = 0; // Between edges, so only the asynchronous path acts
      #1 `CHK(sense_n, 1'b1)
      repeat (2) @(negedge clock);
      rst_b = 1;
      rchk(8'h3E, 8'h00);
      $display("test pin reset done");
      print_verdict();
   end

   // Run needs well under 20000 cycles
   initial begin
      #500_000;
      error_cnt++;
      print_verdict();
   end
endmodule
